// File: logic/fcs_host.sv
// Host-side controller that drives a byte-wide parallel flash through its pins.
// Assumes i_sys_clk at 10 MHz, flash read data arriving asynchronously on i_dq.
//
// Functional notes
// - Chip erase is six fixed unlock writes
// - Id entry by three or six writes
// - Wait 100 us before first read
// - Wait 5 ms before first write
// - Byte loads no more than 200 us apart
`timescale 1ns/1ns
module fcs_host #(
    parameter int PU_WRITE_CYCLES   = fcs_pkg::PU_WRITE_CYC,
    parameter int PAGE_WRITE_CYCLES = fcs_pkg::PAGE_WRITE_CYC,
    parameter int ERASE_CYCLES      = fcs_pkg::ERASE_CYC
) (
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_resetn,
    input  wire logic                      i_req_valid,
    input  wire fcs_pkg::fcs_cmd_e         i_req_cmd,
    input  wire logic [fcs_pkg::ADDR_W-1:0] i_req_addr,
    input  wire logic [fcs_pkg::DATA_W-1:0] i_req_data,
    input  wire logic                      i_page_end,
    output logic                           o_req_ready,
    output logic                           o_rsp_valid,
    output logic [fcs_pkg::DATA_W-1:0]     o_rsp_data,
    output logic                           o_id_mode,
    output logic                           o_busy,
    output logic [fcs_pkg::ADDR_W-1:0]     o_addr,
    output logic [fcs_pkg::DATA_W-1:0]     o_dq_out,
    output logic                           o_dq_oe,
    input  wire logic [fcs_pkg::DATA_W-1:0] i_dq,
    output logic                           o_ce_n,
    output logic                           o_oe_n,
    output logic                           o_we_n
);
    import fcs_pkg::*;

    // Refuse a power-up wait shorter than the read delay, or empty program waits
    if (PU_WRITE_CYCLES < PU_READ_CYC || PAGE_WRITE_CYCLES < 1 ||
        ERASE_CYCLES < 1) begin : g_bad_timing
        $error("fcs_host: timing parameters out of range");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_POWERUP, ST_IDLE, ST_W_SETUP, ST_W_PULSE, ST_W_GAP, ST_R_PULSE,
        ST_LOAD_WAIT, ST_PAUSE, ST_PROG_WAIT
    } fcs_state_e;

    typedef struct packed {
        fcs_state_e             state;
        logic [31:0]            timer;
        logic [31:0]            pu_cnt;
        logic [2:0]             step;
        logic [2:0]             nsteps;
        fcs_cmd_e               cmd;
        logic [ADDR_W-1:0]      addr;
        logic [DATA_W-1:0]      data;
        logic                   id_mode;
        logic                   ready;
        logic                   rsp_valid;
        logic [DATA_W-1:0]      rsp_data;
        logic                   dq_oe;
        logic                   ce_n;
        logic                   oe_n;
        logic                   we_n;
        logic                   busy;
        logic [DATA_W-1:0]      dq_s1;
        logic [DATA_W-1:0]      dq_s2;
    } fcs_state_s;

    fcs_state_s s_r;
    fcs_state_s s_nxt;

    // Address and data of one unlock step; the tail write carries the command
    function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input fcs_cmd_e cmd,
                                                           input logic [2:0] step);
        logic [DATA_W-1:0] last;
        last = DAT_ERASE;
        unique case (cmd)
            FCS_CMD_ID3:     last = DAT_ID3;
            FCS_CMD_ID6:     last = DAT_ID6;
            FCS_CMD_ID_EXIT: last = DAT_ID_EXIT;
            default:         last = DAT_ERASE;
        endcase
        // top address bit is left low so only bits 14..0 carry meaning
        unique case (step)
            3'd0, 3'd3: seq_word = {ADDR_CMD1, DAT_UNLOCK1};
            3'd1, 3'd4: seq_word = {ADDR_CMD2, DAT_UNLOCK2};
            3'd2:       seq_word = {ADDR_CMD1, (cmd == FCS_CMD_ERASE || cmd == FCS_CMD_ID6)
                                               ? DAT_SETUP : last};
            default:    seq_word = {ADDR_CMD1, last};
        endcase
    endfunction : seq_word

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt           = s_r;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.dq_s1     = i_dq;
        s_nxt.dq_s2     = s_r.dq_s1;  // Two-flop catch of the async data pins
        if (s_r.pu_cnt != 32'(PU_WRITE_CYCLES))
            s_nxt.pu_cnt = s_r.pu_cnt + 32'd1;
        unique case (s_r.state)
            ST_POWERUP: begin
                // Writes held off 5 ms, which also covers the 100 us read delay
                if (s_r.pu_cnt == 32'(PU_WRITE_CYCLES)) begin
                    s_nxt.state = ST_IDLE;
                    s_nxt.ready = 1'b1;
                end
            end
            ST_IDLE: begin
                if (i_req_valid) begin
                    s_nxt.ready = 1'b0;
                    s_nxt.cmd   = i_req_cmd;
                    s_nxt.step  = 3'd0;
                    s_nxt.timer = 32'd0;
                    unique case (i_req_cmd)
                        FCS_CMD_READ: begin
                            // in id mode the caller picks maker (0) or device (1)
                            s_nxt.addr  = s_r.id_mode ? (i_req_addr[0] ? ADDR_DEVICE
                                                                        : ADDR_MAKER)
                                                      : i_req_addr;
                            s_nxt.ce_n  = 1'b0;
                            s_nxt.oe_n  = 1'b0;
                            s_nxt.state = ST_R_PULSE;
                        end
                        FCS_CMD_LOAD: begin
                            s_nxt.nsteps = 3'd1;
                            s_nxt.addr   = i_req_addr;
                            s_nxt.data   = i_req_data;
                            s_nxt.state  = ST_W_SETUP;
                        end
                        default: begin
                            s_nxt.nsteps = (i_req_cmd == FCS_CMD_ID3 ||
                                            i_req_cmd == FCS_CMD_ID_EXIT) ? 3'd3 : 3'd6;
                            {s_nxt.addr, s_nxt.data} = seq_word(i_req_cmd, 3'd0);
                            s_nxt.state  = ST_W_SETUP;
                        end
                    endcase
                end
            end
            ST_W_SETUP: begin
                // Address settles before the write strobe falls; the data drive turns on with it
                s_nxt.dq_oe = 1'b1;
                s_nxt.ce_n  = 1'b0;
                s_nxt.we_n  = 1'b0;
                s_nxt.timer = 32'd0;
                s_nxt.state = ST_W_PULSE;
            end
            ST_W_PULSE: begin
                s_nxt.timer = s_r.timer + 32'd1;
                // Select stays low past the write rise so the latch edge is unambiguous
                if (s_r.timer == 32'(STROBE_CYC - 1)) begin
                    s_nxt.we_n  = 1'b1;
                    s_nxt.timer = 32'd0;
                    s_nxt.state = ST_W_GAP;
                end
            end
            ST_W_GAP: begin
                // High time between strobes; data held one cycle past the rise
                s_nxt.dq_oe = 1'b0;
                s_nxt.ce_n  = 1'b1;
                s_nxt.timer = s_r.timer + 32'd1;
                if (s_r.timer == 32'(STROBE_CYC - 1)) begin
                    s_nxt.timer = 32'd0;
                    if (s_r.step + 3'd1 < s_r.nsteps) begin
                        s_nxt.step = s_r.step + 3'd1;
                        {s_nxt.addr, s_nxt.data} = seq_word(s_r.cmd, s_r.step + 3'd1);
                        s_nxt.state = ST_W_SETUP;
                    end else if (s_r.cmd == FCS_CMD_LOAD) begin
                        s_nxt.state = ST_LOAD_WAIT;
                        s_nxt.ready = 1'b1;
                    end else if (s_r.cmd == FCS_CMD_ERASE) begin
                        s_nxt.state = ST_PROG_WAIT;
                    end else begin
                        s_nxt.state = ST_PAUSE;
                    end
                end
            end
            ST_LOAD_WAIT: begin
                // next byte must arrive inside the window or the page closes
                s_nxt.timer = s_r.timer + 32'd1;
                if (i_req_valid && i_req_cmd == FCS_CMD_LOAD && !i_page_end &&
                    s_r.timer < 32'(BYTE_LOAD_CYC - STROBE_CYC * 2 - 2)) begin
                    s_nxt.ready = 1'b0;
                    s_nxt.addr  = i_req_addr;
                    s_nxt.data  = i_req_data;
                    s_nxt.step  = 3'd0;
                    s_nxt.state = ST_W_SETUP;
                end else if (i_page_end ||
                             s_r.timer >= 32'(BYTE_LOAD_CYC - STROBE_CYC * 2 - 2)) begin
                    s_nxt.ready = 1'b0;
                    s_nxt.timer = 32'd0;
                    s_nxt.state = ST_PROG_WAIT;
                end
            end
            ST_PAUSE: begin
                s_nxt.timer = s_r.timer + 32'd1;
                if (s_r.timer == 32'(PAUSE_CYC - 1)) begin
                    s_nxt.id_mode = (s_r.cmd != FCS_CMD_ID_EXIT);
                    s_nxt.ready   = 1'b1;
                    s_nxt.state   = ST_IDLE;
                end
            end
            ST_PROG_WAIT: begin
                // Fixed worst-case wait; the device times itself, no polling needed
                s_nxt.timer = s_r.timer + 32'd1;
                if (s_r.timer == ((s_r.cmd == FCS_CMD_ERASE) ? 32'(ERASE_CYCLES - 1)
                                                           : 32'(PAGE_WRITE_CYCLES - 1))) begin
                    s_nxt.ready = 1'b1;
                    s_nxt.state = ST_IDLE;
                end
            end
            ST_R_PULSE: begin
                // Two-flop data path adds two clocks after the access time
                s_nxt.timer = s_r.timer + 32'd1;
                if (s_r.timer == 32'(STROBE_CYC + 1)) begin
                    s_nxt.rsp_valid = 1'b1;
                    s_nxt.rsp_data  = s_r.dq_s2;
                    s_nxt.ce_n      = 1'b1;
                    s_nxt.oe_n      = 1'b1;
                    s_nxt.ready     = 1'b1;
                    s_nxt.state     = ST_IDLE;
                end
            end
            default: s_nxt.state = ST_IDLE;
        endcase
        // Busy flag registered so the output comes straight from a flop
        s_nxt.busy = (s_nxt.state == ST_PROG_WAIT);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_r       <= '0;
            s_r.state <= ST_POWERUP;
            s_r.ce_n  <= 1'b1;
            s_r.oe_n  <= 1'b1;
            s_r.we_n  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign o_req_ready = s_r.ready;
    assign o_rsp_valid = s_r.rsp_valid;
    assign o_rsp_data  = s_r.rsp_data;
    assign o_id_mode   = s_r.id_mode;
    assign o_busy      = s_r.busy;
    assign o_addr      = s_r.addr;
    assign o_dq_out    = s_r.data;
    assign o_dq_oe     = s_r.dq_oe;
    assign o_ce_n      = s_r.ce_n;
    assign o_oe_n      = s_r.oe_n;
    assign o_we_n      = s_r.we_n;

endmodule : fcs_host

// File: logic/fcs_pkg.sv
// Flash command sequencer package: command codes, pin widths and timing.
// Assumes a 10 MHz system clock driving the host controller.
package fcs_pkg;
    // ----------------------------------------------------------------
    // Clock and times
    // ----------------------------------------------------------------
    localparam int CLK_HZ          = 10_000_000;
    localparam int PAUSE_US        = 10;
    localparam int PU_READ_US      = 100;
    localparam int PU_WRITE_MS     = 5;
    localparam int PAGE_WRITE_MS   = 10;
    localparam int ERASE_MS        = 50;
    localparam int BYTE_LOAD_US    = 200;
    localparam int PAUSE_CYC       = PAUSE_US * (CLK_HZ / 1_000_000);
    localparam int PU_READ_CYC     = PU_READ_US * (CLK_HZ / 1_000_000);
    localparam int PU_WRITE_CYC    = PU_WRITE_MS * (CLK_HZ / 1_000);
    localparam int PAGE_WRITE_CYC  = PAGE_WRITE_MS * (CLK_HZ / 1_000);
    localparam int ERASE_CYC       = ERASE_MS * (CLK_HZ / 1_000);
    localparam int BYTE_LOAD_CYC   = BYTE_LOAD_US * (CLK_HZ / 1_000_000);
    // Strobe phase lengths in clocks (200 ns each, meets pulse widths)
    localparam int STROBE_CYC      = 2;
    // ----------------------------------------------------------------
    // Pins and command codes
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CMD1 = 16'h5555;
    localparam logic [ADDR_W-1:0] ADDR_CMD2 = 16'h2aaa;
    localparam logic [ADDR_W-1:0] ADDR_MAKER = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_DEVICE = 16'h0001;
    localparam logic [DATA_W-1:0] DAT_UNLOCK1 = 8'haa;
    localparam logic [DATA_W-1:0] DAT_UNLOCK2 = 8'h55;
    localparam logic [DATA_W-1:0] DAT_SETUP   = 8'h80;
    localparam logic [DATA_W-1:0] DAT_ERASE   = 8'h10;
    localparam logic [DATA_W-1:0] DAT_ID3     = 8'h90;
    localparam logic [DATA_W-1:0] DAT_ID6     = 8'h60;
    localparam logic [DATA_W-1:0] DAT_ID_EXIT = 8'hf0;
    localparam int TOGGLE_BIT = 6;
    // ----------------------------------------------------------------
    // Host commands
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FCS_CMD_READ,
        FCS_CMD_LOAD,
        FCS_CMD_ERASE,
        FCS_CMD_ID3,
        FCS_CMD_ID6,
        FCS_CMD_ID_EXIT
    } fcs_cmd_e;
endpackage : fcs_pkg

// File: testbench/fcs_flash_model.sv
// Behavioural byte-wide flash: command decoder, id codes, erase timer.
// Assumes the host drives the pins; i_power_n low stands for a power-down.
`timescale 1ns/1ns
module fcs_flash_model #(
    parameter logic [7:0] MAKER_CODE  = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hc3, // Arbitrary value
    parameter int         ERASE_NS    = 8000
) (
    input  wire logic                       i_power_n,
    input  wire logic [fcs_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [fcs_pkg::DATA_W-1:0] i_dq,
    input  wire logic                       i_ce_n,
    input  wire logic                       i_oe_n,
    input  wire logic                       i_we_n,
    output logic [fcs_pkg::DATA_W-1:0]      o_dq
);
    import fcs_pkg::*;
    logic [14:0] wa[$];
    logic [7:0]  wd[$];
    logic        id_mode = 1'b0;
    logic        erased  = 1'b0;
    logic        busy    = 1'b0;
    logic        tgl     = 1'b0;
    logic        u3, u6;
    logic [7:0]  rd;
    logic [7:0]  last_q  = 8'h00;
    time         t_we    = 0;
    // Trailing-write match; any stray write breaks the pattern
    function automatic bit m(input int k, input logic [15:0] a, input logic [7:0] d);
        return wa.size() >= k && wa[wa.size()-k] == a[14:0] && wd[wd.size()-k] == d;
    endfunction : m
    // Writes latch on the rising strobe; only bits 14..0 and 7..0 decode
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_power_n) begin
            wa.push_back(i_addr[14:0]);
            wd.push_back(i_dq);
            t_we = $time;
            u3 = m(3, ADDR_CMD1, DAT_UNLOCK1) && m(2, ADDR_CMD2, DAT_UNLOCK2);
            u6 = u3 && m(6, ADDR_CMD1, DAT_UNLOCK1) && m(5, ADDR_CMD2, DAT_UNLOCK2)
                 && m(4, ADDR_CMD1, DAT_SETUP);
            if (u3 && m(1, ADDR_CMD1, DAT_ID3))
                id_mode = 1'b1;
            if (u3 && m(1, ADDR_CMD1, DAT_ID_EXIT))
                id_mode = 1'b0;
            if (u6 && m(1, ADDR_CMD1, DAT_ID6))
                id_mode = 1'b1;
            if (u6 && m(1, ADDR_CMD1, DAT_ERASE)) begin
                erased = 1'b1;
                busy = 1'b1;
                busy <= #(ERASE_NS) 1'b0;
            end
        end
    end
    // Id mode is volatile
    always @(negedge i_power_n) id_mode = 1'b0;
    always @(negedge i_oe_n) tgl = ~tgl;
    // Read data; a released bus shows the inverse of the last byte
    assign rd = busy ? {1'b0, tgl, 6'h00} : id_mode ? (i_addr[0] ? DEVICE_CODE : MAKER_CODE)
              : erased ? 8'hff : i_addr[7:0] ^ 8'h5a;
    always @* if (!i_ce_n && !i_oe_n) last_q = rd;
    assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~last_q;
endmodule : fcs_flash_model

// File: testbench/fcs_host_assertions.sv
// Checker for the flash host controller: strobes, responses and pauses.
// Assumes it is bound onto fcs_host and sees only its ports.
`timescale 1ns/1ns
module fcs_host_assertions #(
    parameter int PU_WRITE_CYCLES   = fcs_pkg::PU_WRITE_CYC,
    parameter int PAGE_WRITE_CYCLES = fcs_pkg::PAGE_WRITE_CYC,
    parameter int ERASE_CYCLES      = fcs_pkg::ERASE_CYC
) (
    input wire logic                       i_sys_clk,
    input wire logic                       i_resetn,
    input wire logic                       i_req_valid,
    input wire fcs_pkg::fcs_cmd_e          i_req_cmd,
    input wire logic                       o_req_ready,
    input wire logic                       o_rsp_valid,
    input wire logic                       o_id_mode,
    input wire logic                       o_busy,
    input wire logic [fcs_pkg::ADDR_W-1:0] o_addr,
    input wire logic                       o_dq_oe,
    input wire logic                       o_ce_n,
    input wire logic                       o_oe_n,
    input wire logic                       o_we_n
);
    import fcs_pkg::*;
    // Cycles since the write strobe was last low; saturates
    logic [15:0] since_we_r;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn)
            since_we_r <= 16'hffff;
        else if (!o_we_n)
            since_we_r <= 16'h0000;
        else if (since_we_r != 16'hffff)
            since_we_r <= since_we_r + 16'h0001;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_we_held;
        !o_we_n ##1 !o_we_n ##1 o_we_n;
    endsequence
    sequence s_read_rsp;
        !o_rsp_valid [*4] ##1 o_rsp_valid;
    endsequence
    a_reset_idle: assert property ($rose(i_resetn) |-> o_ce_n && o_oe_n && o_we_n
        && !o_dq_oe && !o_req_ready && !o_id_mode) else $error("pins not idle after reset");
    a_write_strobes: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
        else $error("write strobe without select or data drive");
    a_we_width: assert property ($fell(o_we_n) |-> s_we_held)
        else $error("write strobe width wrong");
    a_read_latency: assert property (i_req_valid && o_req_ready && !o_busy
        && i_req_cmd == FCS_CMD_READ |=> s_read_rsp) else $error("read answer late or early");
    a_rsp_pulse: assert property (o_rsp_valid |=> !o_rsp_valid) else $error("rsp too long");
    a_id_read_addr: assert property (o_id_mode && !o_oe_n |-> o_addr[ADDR_W-1:1] == '0)
        else $error("id read with high address bits set");
    a_entry_pause: assert property ($rose(o_id_mode) |-> since_we_r >= PAUSE_CYC - 2)
        else $error("id mode claimed before pause");
    a_exit_pause: assert property ($fell(o_id_mode) |-> since_we_r >= PAUSE_CYC - 2)
        else $error("id exit claimed before pause");
    a_busy_no_req: assert property (o_busy |-> !o_req_ready) else $error("ready while busy");
    a_load_window: assert property ($rose(o_busy) |-> since_we_r <= BYTE_LOAD_CYC)
        else $error("load window overran");
    a_quiet_busy: assert property (o_busy |-> o_oe_n && o_we_n)
        else $error("strobes active during internal cycle");
endmodule : fcs_host_assertions
bind fcs_host fcs_host_assertions #(.PU_WRITE_CYCLES(PU_WRITE_CYCLES),
    .PAGE_WRITE_CYCLES(PAGE_WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_fcs_chk (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
    .i_req_cmd(i_req_cmd), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_id_mode(o_id_mode), .o_busy(o_busy), .o_addr(o_addr), .o_dq_oe(o_dq_oe),
    .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n));

// File: testbench/tb_flash_command_sequencer.sv
// Testbench for the flash host controller against a behavioural flash.
// Assumes fcs_pkg, fcs_host, fcs_flash_model and the bound checker.
`timescale 1ns/1ns
module tb_flash_command_sequencer;
    import fcs_pkg::*;
    localparam int PUW = 1000;
    localparam int PGW = 50;
    localparam int ERW = 80;
    typedef struct {fcs_cmd_e c; logic [15:0] a; logic [7:0] q; logic idm;} fcs_row_s;
    logic        clk = 1'b0, rstn = 1'b0, vld = 1'b0, pend = 1'b0;
    fcs_cmd_e    cmd = FCS_CMD_READ;
    logic [15:0] addr = 16'h0000, pin_addr;
    logic [7:0]  dat = 8'h00, rsp, dq_out, flash_q, bus;
    logic        rdy, rsp_v, idm, busy, dq_oe, ce_n, oe_n, we_n;
    int          n_errors = 0, cmp_count = 0, cyc;
    // Reads and command sequences with the result each should give
    fcs_row_s rows[12] = '{'{FCS_CMD_READ, 16'h0012, 8'h48, 1'b0},
        '{FCS_CMD_ID3, 16'h0000, 8'h00, 1'b1}, '{FCS_CMD_READ, 16'h0000, 8'h3c, 1'b1},
        '{FCS_CMD_READ, 16'hff01, 8'hc3, 1'b1}, '{FCS_CMD_ID_EXIT, 16'h0000, 8'h00, 1'b0},
        '{FCS_CMD_ID6, 16'h0000, 8'h00, 1'b1}, '{FCS_CMD_READ, 16'h0001, 8'hc3, 1'b1},
        '{FCS_CMD_ID_EXIT, 16'h0000, 8'h00, 1'b0}, '{FCS_CMD_READ, 16'h0034, 8'h6e, 1'b0},
        '{FCS_CMD_ERASE, 16'h0000, 8'h00, 1'b0}, '{FCS_CMD_READ, 16'h0034, 8'hff, 1'b0},
        '{FCS_CMD_READ, 16'h0001, 8'hff, 1'b0}};
    always #50 clk = ~clk;
    fcs_host #(.PU_WRITE_CYCLES(PUW), .PAGE_WRITE_CYCLES(PGW), .ERASE_CYCLES(ERW)) DUT (
        .i_sys_clk(clk), .i_resetn(rstn), .i_req_valid(vld), .i_req_cmd(cmd),
        .i_req_addr(addr), .i_req_data(dat), .i_page_end(pend), .o_req_ready(rdy),
        .o_rsp_valid(rsp_v), .o_rsp_data(rsp), .o_id_mode(idm), .o_busy(busy),
        .o_addr(pin_addr), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq(bus),
        .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n));
    // Shared data wire: host wins while it drives
    assign bus = dq_oe ? dq_out : flash_q;
    fcs_flash_model #(.ERASE_NS(ERW * 100)) u_flash (.i_power_n(rstn), .i_addr(pin_addr),
        .i_dq(bus), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .o_dq(flash_q));
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    // Bounded wait on ready (0), busy (1) or response (2); running out fails the run
    task automatic wait_on(input int which, input int lim);
        cyc = 0;
        while (!(which == 0 ? rdy : which == 1 ? busy : rsp_v)) begin
            @(negedge clk);
            cyc++;
            if (cyc > lim) begin
                n_errors++;
                close_out();
            end
        end
    endtask : wait_on
    // Request held from a falling edge until the edge that takes it
    task automatic req(input fcs_cmd_e c, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        vld = 1'b1;
        cmd = c;
        addr = a;
        dat = d;
        wait_on(0, 2000);
        @(negedge clk);
        vld = 1'b0;
    endtask : req
    function automatic logic [23:0] exp_wr(input fcs_cmd_e c, input int i);
        logic [7:0] d;
        d = (i % 3 == 0) ? DAT_UNLOCK1 : DAT_UNLOCK2;
        if (i == 2)
            d = c == FCS_CMD_ID3 ? DAT_ID3 : c == FCS_CMD_ID_EXIT ? DAT_ID_EXIT : DAT_SETUP;
        if (i == 5)
            d = c == FCS_CMD_ID6 ? DAT_ID6 : DAT_ERASE;
        return {(i % 3 == 1) ? ADDR_CMD2 : ADDR_CMD1, d};
    endfunction : exp_wr
    initial begin : main
        int n;
        int len;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        wait_on(0, PUW + 50);
        chk("power-up wait", cyc >= PUW - 1, 1'b1);
        foreach (rows[i]) begin
            req(rows[i].c, rows[i].a, 8'h00);
            if (rows[i].c == FCS_CMD_READ) begin
                wait_on(2, 20);
                chk("read data", rsp, rows[i].q);
            end else begin
                wait_on(0, ERW + 300);
                len = (rows[i].c inside {FCS_CMD_ID3, FCS_CMD_ID_EXIT}) ? 3 : 6;
                n = u_flash.wa.size();
                for (int k = 0; k < len; k++)
                    chk("command write", {1'b0, u_flash.wa[n-len+k], u_flash.wd[n-len+k]},
                        exp_wr(rows[i].c, k));
                chk("pause", ($time - u_flash.t_we) >= 100 *
                    (rows[i].c == FCS_CMD_ERASE ? ERW : PAUSE_CYC), 1'b1);
            end
            chk("id mode", idm, rows[i].idm);
        end
        // Two loads back to back, then close the page early
        req(FCS_CMD_LOAD, 16'h0100, 8'h11);
        req(FCS_CMD_LOAD, 16'h0101, 8'h22);
        wait_on(0, 50);
        n = u_flash.wd.size();
        chk("page bytes", {u_flash.wd[n-2], u_flash.wd[n-1]}, 16'h1122);
        @(negedge clk);
        pend = 1'b1;
        wait_on(1, 20);
        pend = 1'b0;
        for (n = 0; busy && n < PGW + 50; n++)
            @(negedge clk);
        chk("page write wait", n >= PGW - 1, 1'b1);
        // Lone load: the window runs out and programming starts by itself
        req(FCS_CMD_LOAD, 16'h0200, 8'h33);
        wait_on(1, BYTE_LOAD_CYC + 50);
        chk("load window", ($time - u_flash.t_we) <= BYTE_LOAD_CYC * 100, 1'b1);
        wait_on(0, PGW + 50);
        // Power cycle in id mode must come back in array mode
        req(FCS_CMD_ID3, 16'h0000, 8'h00);
        wait_on(0, 300);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        chk("reset pins", {ce_n, oe_n, we_n, dq_oe, rdy}, 5'b11100);
        rstn = 1'b1;
        wait_on(0, PUW + 50);
        chk("id after power cycle", idm, 1'b0);
        req(FCS_CMD_READ, 16'h0001, 8'h00);
        wait_on(2, 20);
        chk("read after power cycle", rsp, 8'hff);
        close_out();
    end
endmodule : tb_flash_command_sequencer
